// [src/eew_pkg.sv]
// shared constants and types for the two-wire eeprom write port
package eew_pkg;

  // array geometry
  localparam int ADDR_W = 16;
  localparam int OFS_W = 7;
  localparam int PAGE_W = ADDR_W - OFS_W;
  localparam int PAGE_BYTES = 128;
  localparam int MEM_BYTES = 65536;
  localparam int CS_W = 3;
  localparam logic [OFS_W-1:0] OFS_ONE = 7'h01;
  localparam logic [OFS_W-1:0] OFS_LAST = 7'h7f;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  // device address word layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int CS_HI = 3;
  localparam int CS_LO = 1;
  localparam int RW_BIT = 0;

  // bit counting inside one word
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // programming time: 5 ms at 40 MHz, longest time so rounded down
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYC_MAX = PROG_TIME_US * CLK_MHZ;
  localparam int TMR_W = 18;
  localparam logic [TMR_W-1:0] TMR_ONE = 18'h0_0001;

  // synchroniser bundles and their bit positions
  localparam int PIN_SYNC_W = 6;
  localparam int PIN_SCL = 5;
  localparam int PIN_SDA = 4;
  localparam int PIN_WP = 3;
  localparam int LINK_SYNC_W = 4;
  localparam int LNK_BUSY = 3;

  // byte engine states on the serial clock
  typedef enum logic [2:0] {LK_DEV, LK_ADDR_HI, LK_ADDR_LO, LK_DATA, LK_IGNORE} eew_link_t;

  // programming sequencer states on the system clock
  typedef enum logic [1:0] {PR_IDLE, PR_COPY, PR_WAIT} eew_prog_t;

endpackage

// [src/eew_sync_if.sv]
// level bundle between a synchroniser and its user
`timescale 1ns/1ps
interface eew_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  // synchroniser side
  modport syn (input raw, output clean);
  // user side
  modport usr (output raw, input clean);
endinterface

// [src/eew_sync.sv]
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module eew_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // raw levels in, settled levels out
  eew_sync_if.syn sif
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;
  logic [W-1:0] agree;
  logic [W-1:0] clean_d;

  // a bit moves only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign clean_d = (agree & s3_q) | (~agree & clean_q);
  assign sif.clean = clean_q;

  // capture chain, undriven straps settle low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= sif.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

endmodule

// [src/eew_top.sv]
// two-wire eeprom target: framing, addressing, page writes, timed programming
`timescale 1ns/1ps

module eew_top
  import eew_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYC_MAX
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial clock from the bus controller
  input wire logic serial_clk,
  // open-drain data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // hardwired straps
  input wire logic [CS_W-1:0] chip_select_pins,
  input wire logic write_protect,
  // array inspection
  input wire logic [ADDR_W-1:0] peek_addr,
  output logic [7:0] peek_data,
  // status
  output logic prog_busy,
  output logic standby
);

  // ---------------- system clock side ----------------

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [CS_W-1:0] cs_s;
  logic scl_p_q;
  logic sda_p_q;
  logic start_ev;
  logic stop_ev;
  logic idle_q;
  logic idle_d;
  logic frame_clr_q;
  logic frame_clr_d;
  logic mask_clr_q;
  logic mask_clr_d;
  logic busy_q;
  logic standby_q;
  logic pr_go;
  logic copy_end;
  logic tmr_done;
  logic cp_we;
  logic [ADDR_W-1:0] cp_addr;
  logic [OFS_W-1:0] ofs_q;
  logic [TMR_W-1:0] tmr_q;
  logic [7:0] peek_q;
  logic [7:0] mem_q [MEM_BYTES];
  eew_prog_t pr_st_q;
  eew_prog_t pr_st_d;

  // ---------------- serial clock side ----------------

  logic link_rst;
  logic mask_rst;
  logic busy_l;
  logic [CS_W-1:0] cs_l;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] byte_w;
  logic word_end;
  logic dev_hit;
  logic ack_q;
  logic ack_d;
  logic ld_hi;
  logic ld_lo;
  logic wr_dat;
  logic sda_oe_q;
  logic sda_out_q;
  logic [ADDR_W-1:0] addr_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [7:0] buf_q [PAGE_BYTES];
  eew_link_t lk_st_q;
  eew_link_t lk_st_d;

  // pin synchroniser on the system clock
  eew_sync_if #(.W(PIN_SYNC_W)) pin_if ();
  assign pin_if.raw = {serial_clk, sda_in, write_protect, chip_select_pins};

  eew_sync #(.W(PIN_SYNC_W)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .sif(pin_if.syn)
  );

  assign cs_s = pin_if.clean[CS_W-1:0];
  assign wp_s = pin_if.clean[PIN_WP];
  assign scl_s = pin_if.clean[PIN_SCL];
  assign sda_s = pin_if.clean[PIN_SDA];

  // previous settled levels for edge checks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // data moving while clock high is a condition
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // bytes were acknowledged, array left alone
  assign pr_go = stop_ev & (pr_st_q == PR_IDLE) & (|mask_q) & ~wp_s;
  assign copy_end = (pr_st_q == PR_COPY) & (ofs_q == OFS_LAST);
  // whole cycle fits the programming time
  assign tmr_done = tmr_q == TMR_W'(PROG_CYC - 1);

  // programming sequencer
  always_comb begin
    pr_st_d = pr_st_q;
    case (pr_st_q)
      // stop ending a write starts programming
      PR_IDLE: if (pr_go) pr_st_d = PR_COPY;
      PR_COPY: if (copy_end) pr_st_d = PR_WAIT;
      PR_WAIT: if (tmr_done) pr_st_d = PR_IDLE;
      default: pr_st_d = PR_IDLE;
    endcase
  end

  // bus framing levels
  assign idle_d = start_ev ? 1'b0 : (stop_ev ? 1'b1 : idle_q);
  // any start, even after a recovery, restarts the byte engine
  assign frame_clr_d = (start_ev | stop_ev) ? 1'b1 :
                       ((~scl_s & ~idle_q) ? 1'b0 : frame_clr_q);
  // page buffer emptied once copied or when nothing is to program
  assign mask_clr_d = ((stop_ev & (pr_st_q == PR_IDLE) & ~pr_go) | copy_end) ? 1'b1 :
                      (start_ev ? 1'b0 : mask_clr_q);

  // framing and status registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_q <= 1'b1;
      frame_clr_q <= 1'b1;
      mask_clr_q <= 1'b1;
      busy_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      idle_q <= idle_d;
      frame_clr_q <= frame_clr_d;
      mask_clr_q <= mask_clr_d;
      busy_q <= pr_st_d != PR_IDLE;
      // standby once bus idle and programming over
      standby_q <= idle_d & (pr_st_d == PR_IDLE);
    end
  end

  // sequencer state, copy index and programming timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pr_st_q <= PR_IDLE;
      ofs_q <= '0;
      tmr_q <= '0;
    end else begin
      pr_st_q <= pr_st_d;
      ofs_q <= (pr_st_q == PR_COPY) ? ofs_q + OFS_ONE : '0;
      tmr_q <= (pr_st_q == PR_IDLE) ? '0 : tmr_q + TMR_ONE;
    end
  end

  // only bytes marked received are copied
  assign cp_we = (pr_st_q == PR_COPY) & mask_q[ofs_q];
  // page bits from the counter, offset from the copy index
  assign cp_addr = {addr_q[ADDR_W-1:OFS_W], ofs_q};

  // array storage
  always_ff @(posedge clk) begin
    if (cp_we) begin
      mem_q[cp_addr] <= buf_q[ofs_q];
    end
  end

  // inspection read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peek_q <= 8'h00;
    end else begin
      peek_q <= mem_q[peek_addr];
    end
  end

  // ---------------- serial clock domain ----------------

  // byte engine is held cleared around each start and stop
  assign link_rst = rst | frame_clr_q;
  assign mask_rst = rst | mask_clr_q;

  // busy and straps into the serial clock domain
  eew_sync_if #(.W(LINK_SYNC_W)) lnk_if ();
  assign lnk_if.raw = {busy_q, cs_s};

  eew_sync #(.W(LINK_SYNC_W)) u_link_sync (
    .clk(serial_clk),
    .rst(rst),
    .sif(lnk_if.syn)
  );

  assign busy_l = lnk_if.clean[LNK_BUSY];
  assign cs_l = lnk_if.clean[CS_W-1:0];

  // word assembled from the live pin at the rising edge
  assign byte_w = {shift_q[6:0], sda_in};
  assign word_end = bit_q == BIT_LAST;
  // chip-select bits must equal the straps
  assign dev_hit = (byte_w[TYPE_HI:TYPE_LO] == DEV_TYPE) &
                   (byte_w[CS_HI:CS_LO] == cs_l) & ~busy_l;

  // byte engine next state and acknowledge decision
  always_comb begin
    lk_st_d = lk_st_q;
    ack_d = 1'b0;
    if (word_end) begin
      case (lk_st_q)
        LK_DEV: begin
          // mismatch left unanswered till next start
          ack_d = dev_hit;
          // low direction bit continues as a write
          lk_st_d = (dev_hit & ~byte_w[RW_BIT]) ? LK_ADDR_HI : LK_IGNORE;
        end
        LK_ADDR_HI: begin
          ack_d = 1'b1;
          lk_st_d = LK_ADDR_LO;
        end
        LK_ADDR_LO: begin
          ack_d = 1'b1;
          lk_st_d = LK_DATA;
        end
        LK_DATA: begin
          // every data byte answered, no limit
          ack_d = 1'b1;
          lk_st_d = LK_DATA;
        end
        default: begin
          ack_d = 1'b0;
          lk_st_d = LK_IGNORE;
        end
      endcase
    end
  end

  // nine clocks per word, ack flag spans clock nine
  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      lk_st_q <= LK_DEV;
      bit_q <= BIT_FIRST;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      lk_st_q <= lk_st_d;
      bit_q <= (bit_q == BIT_ACK) ? BIT_FIRST : bit_q + BIT_ONE;
      shift_q <= byte_w;
      ack_q <= word_end & ack_d;
    end
  end

  // address and data strobes
  assign ld_hi = word_end & (lk_st_q == LK_ADDR_HI);
  assign ld_lo = word_end & (lk_st_q == LK_ADDR_LO);
  assign wr_dat = word_end & (lk_st_q == LK_DATA);

  // counter survives frames, cleared only by reset
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RST;
    end else if (ld_hi) begin
      addr_q <= {byte_w, addr_q[7:0]};
    end else if (ld_lo) begin
      addr_q <= {addr_q[ADDR_W-1:8], byte_w};
    end else if (wr_dat) begin
      // low seven bits wrap, page bits kept
      addr_q <= {addr_q[ADDR_W-1:OFS_W], addr_q[OFS_W-1:0] + OFS_ONE};
    end
  end

  // a wrapped offset overwrites the earlier byte
  always_ff @(posedge serial_clk) begin
    if (wr_dat) begin
      buf_q[addr_q[OFS_W-1:0]] <= byte_w;
    end
  end

  // received offsets marked for the copy
  always_ff @(posedge serial_clk or posedge mask_rst) begin
    if (mask_rst) begin
      mask_q <= '0;
    end else if (wr_dat) begin
      mask_q[addr_q[OFS_W-1:0]] <= 1'b1;
    end
  end

  // acknowledge driven after the falling edge
  // pin only pulled low or released
  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_oe_q <= ack_q;
      sda_out_q <= 1'b0;
    end
  end

  // outputs
  assign sda_oe = sda_oe_q;
  assign sda_out = sda_out_q;
  assign peek_data = peek_q;
  assign prog_busy = busy_q;
  assign standby = standby_q;

endmodule

// [verification/eew_chk.sv]
// assertion checker on the eeprom port pins
`timescale 1ns/1ps
module eew_chk
  import eew_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYC_MAX
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  // data pin
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // straps and inspection
  input wire logic [CS_W-1:0] chip_select_pins,
  input wire logic write_protect,
  input wire logic [ADDR_W-1:0] peek_addr,
  input wire logic [7:0] peek_data,
  // status
  input wire logic prog_busy,
  input wire logic standby
);
  // cycles spent in the current programming run
  int unsigned busy_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 0;
    end else begin
      busy_q <= prog_busy ? busy_q + 1 : 0;
    end
  end
  // start condition and end of programming
  sequence s_start;
    serial_clk && $past(serial_clk) && $fell(sda_in);
  endsequence
  sequence s_done;
    $fell(prog_busy);
  endsequence
  // pin behaviour
  property p_od; @(posedge clk) disable iff (rst) sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_edge; @(posedge clk) disable iff (rst) $changed(sda_oe) |-> !serial_clk; endproperty
  a_edge: assert property (p_edge) else $error("data moved with clock high");
  property p_ack; @(posedge serial_clk) disable iff (rst) sda_oe |=> !sda_oe; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge too long");
  property p_start; @(posedge clk) disable iff (rst) s_start |-> ##[1:8] !standby; endproperty
  a_start: assert property (p_start) else $error("start left standby set");
  // programming cycle
  property p_poll; @(posedge clk) disable iff (rst) prog_busy |-> !sda_oe; endproperty
  a_poll: assert property (p_poll) else $error("ack while programming");
  property p_wp;
    @(posedge clk) disable iff (rst) write_protect && $past(write_protect, 8) |-> !$rose(prog_busy);
  endproperty
  a_wp: assert property (p_wp) else $error("programming under protect");
  property p_max; @(posedge clk) disable iff (rst) prog_busy |-> busy_q < PROG_CYC; endproperty
  a_max: assert property (p_max) else $error("programming too long");
  property p_min; @(posedge clk) disable iff (rst) s_done |-> busy_q > PROG_CYC / 2; endproperty
  a_min: assert property (p_min) else $error("programming cut short");
endmodule

// [verification/eew_ctl_model.sv]
// two-wire bus controller model
`timescale 1ns/1ps
module eew_ctl_model #(
  parameter int HALF = 70
) (
  // serial clock, high between frames
  output logic scl,
  // high pulls the data wire low
  output logic sda_low,
  // resolved data wire
  input wire logic sda_wire
);
  logic tick;
  // 6 ns link tick, lines idle high
  initial begin
    tick = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end
  always #3 tick = ~tick;
  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask
  // data mid low, sampled at rise
  task automatic bit_io(input logic b, output logic s);
    wt(HALF / 2);
    sda_low = ~b;
    wt(HALF / 2);
    scl = 1'b1;
    s = sda_wire;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(2 * HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(HALF / 2);
    sda_low = 1'b1;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask
  // msb first, ninth clock reads ack
  task automatic xfer(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recover(output logic high);
    logic s;
    high = 1'b0;
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, s);
      high = s;
    end
    start();
    stop();
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the eeprom write port
`timescale 1ns/1ps
module tb_top;
  import eew_pkg::*;
  localparam int unsigned PROG_CYC = 600;
  logic clk = 1'b0, rst = 1'b1, wp = 1'b0, scl, ctl_low, h;
  logic sda_out, sda_oe, prog_busy, standby;
  logic [CS_W-1:0] cs_pins = 3'h5;
  logic [ADDR_W-1:0] peek_addr = 16'h0000;
  logic [7:0] peek_data;
  int n_fail = 0, checks_done = 0;
  // pulled-up wire
  wire sda_wire = (sda_oe ? sda_out : 1'b1) & ~ctl_low;
  always #12.5 clk = ~clk;
  eew_top #(.PROG_CYC(PROG_CYC)) eew_top_i (
    .clk(clk), .rst(rst), .serial_clk(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_pins(cs_pins), .write_protect(wp), .peek_addr(peek_addr),
    .peek_data(peek_data), .prog_busy(prog_busy), .standby(standby)
  );
  eew_ctl_model eew_ctl_model_i (.scl(scl), .sda_low(ctl_low), .sda_wire(sda_wire));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic peek(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge clk) peek_addr = a;
    @(negedge clk) d = peek_data;
  endtask
  task automatic poll(input logic [CS_W-1:0] c, input logic [3:0] ty, input logic e);
    logic ack;
    eew_ctl_model_i.start();
    eew_ctl_model_i.xfer({ty, c, 1'b1}, ack);
    chk1("dev ack", e, ack);
    eew_ctl_model_i.stop();
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input int n, input logic [7:0] base);
    logic ack;
    eew_ctl_model_i.start();
    eew_ctl_model_i.xfer({DEV_TYPE, cs_pins, 1'b0}, ack);
    chk1("dev ack", 1'b1, ack);
    eew_ctl_model_i.xfer(a[15:8], ack);
    chk1("hi ack", 1'b1, ack);
    eew_ctl_model_i.xfer(a[7:0], ack);
    chk1("lo ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      eew_ctl_model_i.xfer(base + i[7:0], ack);
      chk1("data ack", 1'b1, ack);
    end
    eew_ctl_model_i.stop();
  endtask
  task automatic wait_prog(input logic e);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < PROG_CYC + 64; i++) begin
      @(negedge clk);
      seen = seen | (prog_busy === 1'b1);
      if (seen && standby === 1'b1) break;
    end
    chk1("prog ran", e, seen);
    chk1("standby", 1'b1, standby);
    if (standby !== 1'b1) close_out();
  endtask
  task automatic t_miss();
    for (int p = 0; p < 2; p++) begin
      @(negedge clk) cs_pins = p ? 3'h2 : 3'h5;
      for (int k = 0; k < 8; k++) begin
        poll(k[2:0], DEV_TYPE, k[2:0] == cs_pins);
      end
    end
    poll(cs_pins, 4'hb, 1'b0);
    @(negedge clk);
    chk1("standby", 1'b1, standby);
    $display("test miss done");
  endtask
  task automatic t_byte();
    logic [7:0] d;
    int i;
    wr(16'h1234, 1, 8'ha5);
    for (i = 0; i < 40 && prog_busy !== 1'b1; i++) @(negedge clk);
    chk1("busy", 1'b1, prog_busy);
    poll(cs_pins, DEV_TYPE, 1'b0);
    wait_prog(1'b1);
    poll(cs_pins, DEV_TYPE, 1'b1);
    peek(16'h1234, d);
    chk8("byte", 8'ha5, d);
    $display("test byte done");
  endtask
  task automatic t_page();
    logic [7:0] d;
    int n;
    wr(16'h0b7e, 129, 8'h10);
    wait_prog(1'b1);
    for (int o = 0; o < PAGE_BYTES; o++) begin
      n = (o + 2) % 128;
      if (n == 0) n = 128;
      peek({9'h016, o[6:0]}, d);
      chk8("page", 8'h10 + n[7:0], d);
    end
    $display("test page done");
  endtask
  task automatic t_part();
    logic [7:0] d;
    wr(16'h0b10, 2, 8'hc0);
    wait_prog(1'b1);
    peek(16'h0b10, d);
    chk8("part0", 8'hc0, d);
    peek(16'h0b11, d);
    chk8("part1", 8'hc1, d);
    peek(16'h0b12, d);
    chk8("kept", 8'h24, d);
    $display("test part done");
  endtask
  task automatic t_wp();
    logic [7:0] d;
    @(negedge clk) wp = 1'b1;
    wr(16'h1234, 1, 8'h5a);
    wait_prog(1'b0);
    peek(16'h1234, d);
    chk8("protected", 8'ha5, d);
    @(negedge clk) wp = 1'b0;
    $display("test protect done");
  endtask
  task automatic t_rst();
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk1("standby", 1'b1, standby);
    chk1("busy", 1'b0, prog_busy);
    eew_ctl_model_i.recover(h);
    chk1("line high", 1'b1, h);
    $display("test reset done");
  endtask
  initial begin
    t_rst();
    t_miss();
    t_byte();
    t_page();
    t_part();
    t_wp();
    close_out();
  end
endmodule
bind eew_top eew_chk #(.PROG_CYC(PROG_CYC)) eew_chk_i (
  .clk(clk), .rst(rst), .serial_clk(serial_clk), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_pins(chip_select_pins), .write_protect(write_protect),
  .peek_addr(peek_addr), .peek_data(peek_data), .prog_busy(prog_busy), .standby(standby)
);
